// File: rtl/abc_block_cipher.sv
// What this block does
// - Encrypts or decrypts, key length selectable as 128 or 256 bits.
// - Each operation transforms exactly one 128-bit data block.
// - A 128-bit key operation completes in 52 core clock cycles.
// - A 256-bit key operation completes in 75 core clock cycles.
// - Data and key registers are reachable through an AHB slave port.
`timescale 1ns/1ps
`default_nettype none
module abc_block_cipher (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    output logic busy_o,
    output logic done_o
);
    // Galois field multiply
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = {x[6:0], 1'b0} ^ (x[7] ? abc_pkg::GF_POLY : 8'h00);
        end
        return p;
    endfunction
    // Multiplicative inverse as a to the 254th
    function automatic logic [7:0] ginv(input logic [7:0] a);
        logic [7:0] p;
        logic [7:0] r;
        p = a;
        r = 8'h01;
        for (int k = 1; k < 8; k++) begin
            p = gmul(p, p);
            r = gmul(r, p);
        end
        return r;
    endfunction
    function automatic logic [7:0] rotl(input logic [7:0] a, input int n);
        return 8'((a << n) | (a >> (8 - n)));
    endfunction
    function automatic logic [7:0] sbox(input logic [7:0] a);
        logic [7:0] i;
        i = ginv(a);
        return i ^ rotl(i, 1) ^ rotl(i, 2) ^ rotl(i, 3) ^ rotl(i, 4) ^ abc_pkg::SBOX_AFF;
    endfunction
    function automatic logic [7:0] inv_sbox(input logic [7:0] a);
        return ginv(rotl(a, 1) ^ rotl(a, 3) ^ rotl(a, 6) ^ abc_pkg::INV_AFF);
    endfunction
    function automatic logic [31:0] sub_word(input logic [31:0] w);
        return {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
    endfunction
    // Round constant for expansion step n
    function automatic logic [7:0] rcon(input int n);
        logic [7:0] r;
        r = 8'h01;
        for (int k = 2; k <= abc_pkg::NR_128; k++) begin
            if (k <= n) begin
                r = gmul(r, 8'h02);
            end
        end
        return r;
    endfunction
    // Column mix with a coefficient row
    function automatic logic [127:0] mix(input logic [127:0] s, input logic [31:0] cf);
        logic [127:0] t;
        logic [7:0] a [4];
        t = s;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                a[r] = s[127 - 8 * (4 * c + r) -: 8];
            end
            for (int r = 0; r < 4; r++) begin
                t[127 - 8 * (4 * c + r) -: 8] = gmul(a[r], cf[31:24])
                    ^ gmul(a[(r + 1) % 4], cf[23:16])
                    ^ gmul(a[(r + 2) % 4], cf[15:8])
                    ^ gmul(a[(r + 3) % 4], cf[7:0]);
            end
        end
        return t;
    endfunction
    // One forward round
    function automatic logic [127:0] enc_round(input logic [127:0] s, input logic [127:0] rk,
        input logic last);
        logic [127:0] t;
        t = s;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                t[127 - 8 * (4 * c + r) -: 8] = sbox(s[127 - 8 * (4 * ((c + r) % 4) + r) -: 8]);
            end
        end
        if (!last) begin
            t = mix(t, abc_pkg::MIX_ENC);
        end
        return t ^ rk;
    endfunction
    // One inverse round
    function automatic logic [127:0] dec_round(input logic [127:0] s, input logic [127:0] rk,
        input logic last);
        logic [127:0] t;
        t = s;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                t[127 - 8 * (4 * c + r) -: 8] =
                    inv_sbox(s[127 - 8 * (4 * ((c - r + 4) % 4) + r) -: 8]);
            end
        end
        t = t ^ rk;
        if (!last) begin
            t = mix(t, abc_pkg::MIX_DEC);
        end
        return t;
    endfunction
    abc_pkg::abc_state_t st, next_st;
    logic [6:0] cnt, next_cnt;
    logic [1:0] ctrl, next_ctrl;
    logic done, next_done;
    logic [31:0] data_w [abc_pkg::DATA_WORDS];
    logic [31:0] next_data_w [abc_pkg::DATA_WORDS];
    logic [31:0] key_w [abc_pkg::KEY_WORDS];
    logic [31:0] next_key_w [abc_pkg::KEY_WORDS];
    logic [31:0] sched [abc_pkg::WORDS_MAX];
    logic [31:0] next_sched [abc_pkg::WORDS_MAX];
    logic wr_pend, next_wr_pend;
    logic [11:0] wr_addr, next_wr_addr;
    logic [31:0] rdata, next_rdata;

    // Bus decode, register writes and cipher engine
    always_comb begin
        logic [127:0] blk;
        logic [31:0] tmp;
        logic [11:0] ra;
        int nk;
        int nr;
        int elen;
        int ph;
        int wi;
        int ri;
        logic [6:0] total;
        logic go;
        nk = abc_pkg::NK_128;
        nr = abc_pkg::NR_128;
        elen = abc_pkg::NW_128 - abc_pkg::NK_128;
        total = abc_pkg::CYC_KEY128;
        ri = 0;
        blk = {data_w[0], data_w[1], data_w[2], data_w[3]};
        tmp = 32'h0000_0000;
        ra = haddr_i[11:0];
        next_st = st;
        next_cnt = cnt;
        next_ctrl = ctrl;
        next_done = done;
        next_data_w = data_w;
        next_key_w = key_w;
        next_sched = sched;
        next_rdata = rdata;
        go = 1'b0;
        next_wr_pend = hsel_i & hready_i & htrans_i[1] & hwrite_i & (hsize_i == abc_pkg::HSIZE_WORD);
        next_wr_addr = haddr_i[11:0];
        // read data for the data phase
        if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
            next_rdata = 32'h0000_0000;
            if (ra == abc_pkg::OFS_CTRL) begin
                next_rdata = {30'h0, ctrl};
            end else if (ra == abc_pkg::OFS_STATUS) begin
                next_rdata[abc_pkg::STAT_BUSY_BIT] = (st == abc_pkg::ST_BUSY);
                next_rdata[abc_pkg::STAT_DONE_BIT] = done;
            end else if (ra[11:4] == abc_pkg::OFS_DATA[11:4]) begin
                next_rdata = data_w[ra[3:2]];
            end else if (ra[11:5] == abc_pkg::OFS_KEY[11:5]) begin
                next_rdata = key_w[ra[4:2]];
            end
        end
        // data phase writes, ignored while busy
        if (wr_pend && st == abc_pkg::ST_IDLE) begin
            if (wr_addr == abc_pkg::OFS_CTRL) begin
                next_ctrl = hwdata_i[1:0];
            end else if (wr_addr == abc_pkg::OFS_CMD) begin
                go = hwdata_i[abc_pkg::CMD_START_BIT];
            end else if (wr_addr[11:4] == abc_pkg::OFS_DATA[11:4]) begin
                next_data_w[wr_addr[3:2]] = hwdata_i;
            end else if (wr_addr[11:5] == abc_pkg::OFS_KEY[11:5]) begin
                next_key_w[wr_addr[4:2]] = hwdata_i;
            end
        end
        if (ctrl[abc_pkg::CTRL_KEY256_BIT]) begin
            nk = abc_pkg::NK_256;
            nr = abc_pkg::NR_256;
            elen = abc_pkg::NW_256 - abc_pkg::NK_256;
            total = abc_pkg::CYC_KEY256;
        end
        wi = nk + int'(cnt);
        ph = int'(cnt) - elen;
        case (st)
            abc_pkg::ST_IDLE: begin
                if (go) begin
                    next_st = abc_pkg::ST_BUSY;
                    next_cnt = 7'h00;
                    next_done = 1'b0;
                    for (int k = 0; k < abc_pkg::KEY_WORDS; k++) begin
                        next_sched[k] = key_w[k];
                    end
                end
            end
            abc_pkg::ST_BUSY: begin
                next_cnt = cnt + 7'h01;
                if (ph < 0) begin
                    // Key expansion, one word per cycle
                    tmp = sched[wi - 1];
                    if (wi % nk == 0) begin
                        tmp = sub_word({tmp[23:0], tmp[31:24]}) ^ {rcon(wi / nk), 24'h0};
                    end else if (nk == abc_pkg::NK_256 && wi % nk == 4) begin
                        tmp = sub_word(tmp);
                    end
                    next_sched[wi] = sched[wi - nk] ^ tmp;
                end else if (ph <= nr) begin
                    // one 128-bit block, one round per cycle
                    ri = ctrl[abc_pkg::CTRL_DECRYPT_BIT] ? nr - ph : ph; // Decrypt walks keys down
                    if (ph == 0) begin
                        blk = blk ^ {sched[4 * ri], sched[4 * ri + 1], sched[4 * ri + 2],
                            sched[4 * ri + 3]};
                    end else if (ctrl[abc_pkg::CTRL_DECRYPT_BIT]) begin
                        blk = dec_round(blk, {sched[4 * ri], sched[4 * ri + 1],
                            sched[4 * ri + 2], sched[4 * ri + 3]}, ph == nr);
                    end else begin
                        blk = enc_round(blk, {sched[4 * ri], sched[4 * ri + 1],
                            sched[4 * ri + 2], sched[4 * ri + 3]}, ph == nr);
                    end
                    for (int k = 0; k < abc_pkg::DATA_WORDS; k++) begin
                        next_data_w[k] = blk[127 - 32 * k -: 32];
                    end
                end
                // finish on the exact cycle count
                if (cnt == total - 7'h01) begin
                    next_st = abc_pkg::ST_IDLE;
                    next_done = 1'b1;
                end
            end
            default: begin
                next_st = abc_pkg::ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= abc_pkg::ST_IDLE;
            cnt <= 7'h00;
            ctrl <= abc_pkg::CTRL_RESET;
            done <= 1'b0;
            data_w <= '{default: 32'h0000_0000};
            key_w <= '{default: 32'h0000_0000};
            sched <= '{default: 32'h0000_0000};
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            rdata <= 32'h0000_0000;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            ctrl <= next_ctrl;
            done <= next_done;
            data_w <= next_data_w;
            key_w <= next_key_w;
            sched <= next_sched;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            rdata <= next_rdata;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = abc_pkg::HRESP_OKAY;
    assign hrdata_o = rdata;
    assign busy_o = (st == abc_pkg::ST_BUSY);
    assign done_o = done;
endmodule
`default_nettype wire

// File: include/abc_pkg.sv
`default_nettype none
package abc_pkg;
    // Block timing in core clock cycles per key length
    localparam logic [6:0] CYC_KEY128 = 7'h34; // 52 cycles
    localparam logic [6:0] CYC_KEY256 = 7'h4B; // 75 cycles
    // Key schedule geometry
    localparam int NK_128 = 4;
    localparam int NK_256 = 8;
    localparam int NR_128 = 10;
    localparam int NR_256 = 14;
    localparam int NW_128 = 44;
    localparam int NW_256 = 60;
    localparam int WORDS_MAX = 60;
    localparam int KEY_WORDS = 8;
    localparam int DATA_WORDS = 4;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_DATA = 12'h010;
    localparam logic [11:0] OFS_KEY = 12'h020;
    // Field positions
    localparam int CTRL_DECRYPT_BIT = 0;
    localparam int CTRL_KEY256_BIT = 1;
    localparam int CMD_START_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;
    // Field arithmetic constants
    localparam logic [7:0] GF_POLY = 8'h1B;
    localparam logic [7:0] SBOX_AFF = 8'h63;
    localparam logic [7:0] INV_AFF = 8'h05;
    localparam logic [31:0] MIX_ENC = 32'h02030101;
    localparam logic [31:0] MIX_DEC = 32'h0E0B0D09;
    // Engine states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_BUSY = 2'h2
    } abc_state_t;
endpackage
`default_nettype wire

// File: sim/abc_block_cipher_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module abc_block_cipher_asserts (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic busy_o,
    input wire logic done_o
);
    logic pend, next_pend, k256, next_k256;
    logic [6:0] cnt, next_cnt;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // Key length shadow and busy cycle count
    always_comb begin
        next_pend = hsel_i & hready_i & htrans_i[1] & hwrite_i
            & (hsize_i == abc_pkg::HSIZE_WORD) & (haddr_i[11:0] == abc_pkg::OFS_CTRL);
        next_k256 = (pend & ~busy_o) ? hwdata_i[abc_pkg::CTRL_KEY256_BIT] : k256;
        next_cnt = busy_o ? cnt + 7'h01 : 7'h00;
    end
    // Helper registers
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend <= 1'h0;
            k256 <= 1'h0;
            cnt <= 7'h00;
        end else begin
            pend <= next_pend;
            k256 <= next_k256;
            cnt <= next_cnt;
        end
    end
    sequence s_begin; $rose(busy_o); endsequence
    sequence s_end; $fell(busy_o); endsequence
    property p_ready; hreadyout_o == 1'h1; endproperty
    property p_okay; hresp_o == abc_pkg::HRESP_OKAY; endproperty
    property p_len128; s_end |-> k256 || cnt == abc_pkg::CYC_KEY128; endproperty
    property p_len256; s_end |-> !k256 || cnt == abc_pkg::CYC_KEY256; endproperty
    property p_done; s_end |-> done_o; endproperty
    property p_clear; s_begin |-> !done_o; endproperty
    property p_excl; busy_o |-> !done_o; endproperty
    a_ready: assert property (p_ready) else $error("ready dropped");
    a_okay: assert property (p_okay) else $error("response not okay");
    a_len128: assert property (p_len128) else $error("short key run length");
    a_len256: assert property (p_len256) else $error("long key run length");
    a_done: assert property (p_done) else $error("no done at end");
    a_clear: assert property (p_clear) else $error("done kept at start");
    a_excl: assert property (p_excl) else $error("done while busy");
endmodule
bind abc_block_cipher abc_block_cipher_asserts abc_block_cipher_asserts_i (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .busy_o(busy_o), .done_o(done_o));
`default_nettype wire

// File: sim/abc_ahb_master.sv
`timescale 1ns/1ps
`default_nettype none
module abc_ahb_master (
    input wire logic core_clk_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o,
    output logic hready_o
);
    // Idle bus at time zero
    initial begin
        hsel_o = 1'h0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'h0;
        hsize_o = abc_pkg::HSIZE_WORD;
        hwdata_o = 32'h0;
        hready_o = 1'h1;
    end
    // Address phase; stale write data inverted
    task automatic addr(input logic [11:0] a, input logic w, input logic [2:0] s);
        @(negedge core_clk_i);
        hsel_o = 1'h1;
        htrans_o = 2'h2;
        haddr_o = {20'h0, a};
        hwrite_o = w;
        hsize_o = s;
        hwdata_o = ~hwdata_o;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [2:0] s);
        addr(a, 1'h1, s);
        @(negedge core_clk_i);
        hsel_o = 1'h0;
        htrans_o = 2'h0;
        hwdata_o = d;
        @(posedge core_clk_i);
    endtask
    // Read data taken at data phase edge
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        addr(a, 1'h0, abc_pkg::HSIZE_WORD);
        @(negedge core_clk_i);
        hsel_o = 1'h0;
        htrans_o = 2'h0;
        @(posedge core_clk_i);
        d = hrdata_i;
    endtask
endmodule
`default_nettype wire

// File: sim/tb_abc_block_cipher.sv
`timescale 1ns/1ps
`default_nettype none
module tb_abc_block_cipher;
    logic core_clk_i, rstn_i, hsel, hwrite, hready, hreadyout_o, hresp_o, busy_o, done_o;
    logic [31:0] haddr, hwdata, hrdata_o;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int fails = 0;
    int checked = 0;
    localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
    localparam logic [127:0] CT1 = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    localparam logic [127:0] CT2 = 128'h8EA2B7CA516745BFEAFC49904B496089;
    abc_block_cipher abc_block_cipher_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .hrdata_o(hrdata_o), .busy_o(busy_o), .done_o(done_o));
    abc_ahb_master abc_ahb_master_i (.core_clk_i(core_clk_i), .hrdata_i(hrdata_o),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata), .hready_o(hready));
    // Core clock, 50 ns period
    initial begin
        core_clk_i = 1'h0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One block operation, optional pokes while busy
    task automatic op(input logic [1:0] c, input int nk, input logic [127:0] din,
        input logic [127:0] e, input int cyc, input bit poke);
        logic [31:0] d;
        logic [127:0] got;
        int n;
        abc_ahb_master_i.wr(abc_pkg::OFS_CTRL, {30'h0, c}, abc_pkg::HSIZE_WORD);
        for (int i = 0; i < nk; i++) begin
            d = 32'h00010203 + 32'(i) * 32'h04040404;
            abc_ahb_master_i.wr(abc_pkg::OFS_KEY + 12'(4 * i), d, abc_pkg::HSIZE_WORD);
        end
        for (int i = 0; i < 4; i++) begin
            d = din[127 - 32 * i -: 32];
            abc_ahb_master_i.wr(abc_pkg::OFS_DATA + 12'(4 * i), d, abc_pkg::HSIZE_WORD);
        end
        abc_ahb_master_i.wr(abc_pkg::OFS_CMD, 32'h1, abc_pkg::HSIZE_WORD);
        if (poke) begin
            abc_ahb_master_i.wr(abc_pkg::OFS_DATA, 32'h0, abc_pkg::HSIZE_WORD);
            abc_ahb_master_i.wr(abc_pkg::OFS_CMD, 32'h1, abc_pkg::HSIZE_WORD);
            abc_ahb_master_i.rd(abc_pkg::OFS_STATUS, d);
            chk("busy", d, 128'h1);
        end
        n = 0;
        @(negedge core_clk_i);
        while (busy_o === 1'h1 && n < 200) begin
            n++;
            @(negedge core_clk_i);
        end
        chk("cycles", 128'(n), 128'(cyc - (poke ? 6 : 0)));
        chk("done", done_o, 128'h1);
        abc_ahb_master_i.rd(abc_pkg::OFS_STATUS, d);
        chk("status", d, 128'h2);
        for (int i = 0; i < 4; i++) begin
            abc_ahb_master_i.rd(abc_pkg::OFS_DATA + 12'(4 * i), d);
            got[127 - 32 * i -: 32] = d;
        end
        chk("block", got, e);
        abc_ahb_master_i.rd(abc_pkg::OFS_KEY, d);
        chk("key0", d, 128'h00010203);
        abc_ahb_master_i.rd(abc_pkg::OFS_CTRL, d);
        chk("ctrl", d, 128'(c));
    endtask
    task automatic t_reset();
        chk("ready", hreadyout_o, 128'h1);
        chk("resp", hresp_o, 128'h0);
        chk("idle", {busy_o, done_o, hrdata_o}, 128'h0);
    endtask
    task automatic t_short();
        op(2'h0, 4, PT, CT1, 52, 1'h1);
        op(2'h1, 4, CT1, PT, 52, 1'h0);
    endtask
    task automatic t_long();
        op(2'h2, 8, PT, CT2, 75, 1'h0);
        op(2'h3, 8, CT2, PT, 75, 1'h0);
    endtask
    // Narrow writes dropped, unmapped read is zero
    task automatic t_narrow();
        logic [31:0] d;
        abc_ahb_master_i.wr(abc_pkg::OFS_DATA, 32'hDEADBEEF, 3'h0);
        abc_ahb_master_i.wr(abc_pkg::OFS_DATA + 12'h4, 32'hDEADBEEF, 3'h1);
        abc_ahb_master_i.rd(abc_pkg::OFS_DATA, d);
        chk("data0", d, 128'h00112233);
        abc_ahb_master_i.rd(abc_pkg::OFS_DATA + 12'h4, d);
        chk("data1", d, 128'h44556677);
        abc_ahb_master_i.rd(12'h100, d);
        chk("unmapped", d, 128'h0);
    endtask
    initial begin
        #1000000;
        fails++;
        conclude();
    end
    initial begin
        rstn_i = 1'h0;
        repeat (8) @(posedge core_clk_i);
        @(negedge core_clk_i);
        t_reset();
        rstn_i = 1'h1;
        t_short();
        t_long();
        t_narrow();
        conclude();
    end
endmodule
`default_nettype wire
